// ===== verilog/ads_defs.vh
/*
 * constants for the adapter dma request and wait-state support block:
 * register offsets, field positions, reset values and timing figures.
 * assumes inclusion by bare name from the design file and the bench.
 */
`ifndef ADS_DEFS_VH
`define ADS_DEFS_VH

// register byte offsets on the axi4-lite slave
`define ADS_ADDR_W 4
`define ADS_OFF_CONFIG 4'h0
`define ADS_OFF_STATUS 4'h4
`define ADS_OFF_PORT 4'h8

// config register fields
`define ADS_CFG_DMA_EN 0
`define ADS_CFG_BURST 1
`define ADS_CFG_CHAN 2
`define ADS_CFG_WAIT_LO 4
`define ADS_CFG_WAIT_HI 6
`define ADS_CFG_FLOOR 7
`define ADS_CFG_RESET 8'h84

// status register fields
`define ADS_ST_REQ_LO 0
`define ADS_ST_BURST_N 2
`define ADS_ST_SINGLE_N 3
`define ADS_ST_CHRDY 4
`define ADS_ST_BUSY 5
`define ADS_ST_CNT_LO 8
`define ADS_ST_CNT_HI 10

// axi responses
`define ADS_RESP_OKAY 2'h0
`define ADS_RESP_SLVERR 2'h2
`define ADS_RESP_DECERR 2'h3

// timing, in nanoseconds and oscillator periods
`define ADS_OSC_PERIOD_NS 70
`define ADS_MIN_STROBE_NS 360
`define ADS_NON_DMA_STROBE_NS 250
`define ADS_WAIT_MAX 6

// width of the wait counter, port reset value and synchroniser width
`define ADS_CNT_W 3
`define ADS_PORT_RESET 8'h00
`define ADS_SYNC_W 15

`endif

// ===== verilog/ads_support.v
/*
 * adapter support logic: dma request source selector, wait-state
 * generator driving channel ready, and an eight-bit output port read back over axi,
 * the selector and generator configured over an axi4-lite slave.
 * assumes all board-side pins and the bus oscillator are asynchronous
 * to aclk and that aclk is far faster than the oscillator.
 */
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ads_defs.vh"

////////////////////////////////////////////////////////////////////////
module ads_support (
  input wire aclk, // 250 mhz system clock
  input wire aresetn, // synchronous reset, active low
  input wire clk_en, // freezes all state while low
  // axi4-lite slave
  input wire [`ADS_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte enables
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [`ADS_ADDR_W-1:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  // board side
  input wire osc, // bus oscillator, about 70 ns
  input wire [1:0] serial_wait_request_n, // channel requests, low
  input wire bus_grant, // grant, high active
  input wire status_s0_n, // bus status s0, low active
  input wire status_s1_n, // bus status s1, low active
  input wire serial_chip_enable_n, // serial controller select
  input wire decoded_select_n, // output port select, low
  input wire io_write_strobe_n, // io write strobe, low
  input wire [7:0] port_data, // board data bus
  output reg burst_request_in_n, // burst request out, low
  output reg single_request_in_n, // single request out, low
  output reg channel_ready, // bus channel ready, low = wait
  output reg [7:0] gp_out // general output lines
);

  localparam integer WAIT_MAX_I = `ADS_WAIT_MAX;
  // least whole oscillator periods covering each strobe width
  localparam integer WAIT_DMA_I =
    (`ADS_MIN_STROBE_NS + `ADS_OSC_PERIOD_NS - 1) / `ADS_OSC_PERIOD_NS;
  localparam integer WAIT_FLOOR_I =
    (`ADS_NON_DMA_STROBE_NS + `ADS_OSC_PERIOD_NS - 1) /
    `ADS_OSC_PERIOD_NS;
  // cut to the counter width on purpose; all fit in three bits
  localparam [`ADS_CNT_W-1:0] WAIT_MAX = WAIT_MAX_I[`ADS_CNT_W-1:0];
  localparam [`ADS_CNT_W-1:0] WAIT_DMA = WAIT_DMA_I[`ADS_CNT_W-1:0];
  localparam [`ADS_CNT_W-1:0] WAIT_FLOOR = WAIT_FLOOR_I[`ADS_CNT_W-1:0];

  function [1:0] reg_sel;
    input [`ADS_ADDR_W-1:0] addr;
    begin
      if (addr == `ADS_OFF_CONFIG) begin
        reg_sel = 2'h1;
      end else if (addr == `ADS_OFF_STATUS) begin
        reg_sel = 2'h2;
      end else if (addr == `ADS_OFF_PORT) begin
        reg_sel = 2'h3;
      end else begin
        reg_sel = 2'h0;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // input synchronisers

  wire [`ADS_SYNC_W-1:0] async_in;
  reg [`ADS_SYNC_W-1:0] sync1_q;
  reg [`ADS_SYNC_W-1:0] sync2_q;
  reg osc_prev_q;
  reg ce_n_prev_q;
  reg wr_n_prev_q;
  // previous values reset to the idle level: no false edge out of reset

  assign async_in = {port_data, io_write_strobe_n, decoded_select_n,
    serial_chip_enable_n, status_s1_n, status_s0_n, bus_grant, osc};

  wire osc_s = sync2_q[0];
  wire grant_s = sync2_q[1];
  wire s0_n_s = sync2_q[2];
  wire s1_n_s = sync2_q[3];
  wire ce_n_s = sync2_q[4];
  wire sel_n_s = sync2_q[5];
  wire wr_n_s = sync2_q[6];
  wire [7:0] data_s = sync2_q[14:7];

  reg [1:0] req1_q;
  reg [1:0] req_s_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= {`ADS_SYNC_W{1'b1}};
      sync2_q <= {`ADS_SYNC_W{1'b1}};
      req1_q <= 2'h3;
      req_s_q <= 2'h3;
      osc_prev_q <= 1'b1;
      ce_n_prev_q <= 1'b1;
      wr_n_prev_q <= 1'b1;
    end else if (clk_en) begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      req1_q <= serial_wait_request_n;
      req_s_q <= req1_q;
      osc_prev_q <= osc_s;
      ce_n_prev_q <= ce_n_s;
      wr_n_prev_q <= wr_n_s;
    end
  end

  wire osc_rise = osc_s & ~osc_prev_q;
  wire ce_fall = ~ce_n_s & ce_n_prev_q;
  wire wr_fall = ~wr_n_s & wr_n_prev_q;

  //////////////////////////////////////////////////////////////////////
  // configuration register and axi4-lite slave

  reg [7:0] cfg_q;
  reg aw_held_q;
  reg w_held_q;
  reg [`ADS_ADDR_W-1:0] awaddr_q;
  reg [7:0] wbyte_q;
  reg wlane_q;

  wire dma_en = cfg_q[`ADS_CFG_DMA_EN];
  wire burst_mode = cfg_q[`ADS_CFG_BURST];
  wire chan_sel = cfg_q[`ADS_CFG_CHAN];
  wire floor_en = cfg_q[`ADS_CFG_FLOOR];
  wire [`ADS_CNT_W-1:0] wait_cfg = cfg_q[`ADS_CFG_WAIT_HI:`ADS_CFG_WAIT_LO];

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held_q | aw_take;
  wire w_have = w_held_q | w_take;
  wire do_write = aw_have & w_have & ~s_axi_bvalid;
  wire [`ADS_ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [7:0] wr_byte = w_held_q ? wbyte_q : s_axi_wdata[7:0];
  wire wr_lane = w_held_q ? wlane_q : s_axi_wstrb[0];
  wire [1:0] wr_sel = reg_sel(wr_addr);
  wire [1:0] rd_sel = reg_sel(s_axi_araddr);

  reg [`ADS_CNT_W-1:0] cnt_q;
  reg busy_q;
  reg [31:0] status_word;

  // status fields placed at their defined bit positions
  always @* begin
    status_word = 32'h0000_0000;
    status_word[`ADS_ST_REQ_LO+1:`ADS_ST_REQ_LO] = req_s_q;
    status_word[`ADS_ST_BURST_N] = burst_request_in_n;
    status_word[`ADS_ST_SINGLE_N] = single_request_in_n;
    status_word[`ADS_ST_CHRDY] = channel_ready;
    status_word[`ADS_ST_BUSY] = busy_q;
    status_word[`ADS_ST_CNT_HI:`ADS_ST_CNT_LO] = cnt_q;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= `ADS_CFG_RESET;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= {`ADS_ADDR_W{1'b0}};
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `ADS_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      // address and data may arrive in either order
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      aw_held_q <= aw_have & ~do_write;
      w_held_q <= w_have & ~do_write;
      s_axi_awready <= ~(aw_have & ~do_write) & ~do_write &
        ~(s_axi_bvalid & ~s_axi_bready);
      s_axi_wready <= ~(w_have & ~do_write) & ~do_write &
        ~(s_axi_bvalid & ~s_axi_bready);
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        if (wr_sel == 2'h1) begin
          s_axi_bresp <= `ADS_RESP_OKAY;
          if (wr_lane) begin
            cfg_q <= wr_byte;
          end
        end else if (wr_sel == 2'h0) begin
          s_axi_bresp <= `ADS_RESP_DECERR;
        end else begin
          s_axi_bresp <= `ADS_RESP_SLVERR;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // read channel: one read at a time
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        if (rd_sel == 2'h1) begin
          s_axi_rdata <= {24'h00_0000, cfg_q};
          s_axi_rresp <= `ADS_RESP_OKAY;
        end else if (rd_sel == 2'h2) begin
          s_axi_rdata <= status_word;
          s_axi_rresp <= `ADS_RESP_OKAY;
        end else if (rd_sel == 2'h3) begin
          s_axi_rdata <= {24'h00_0000, gp_out};
          s_axi_rresp <= `ADS_RESP_OKAY;
        end else begin
          // unmapped offsets answer decode error with zero data
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `ADS_RESP_DECERR;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // dma request source selector

  // only the selected channel is looked at
  wire req_sel_n = chan_sel ? req_s_q[1] : req_s_q[0];
  wire req_active = dma_en & ~req_sel_n;
  wire xfer_start = grant_s & ~s0_n_s & ~s1_n_s;
  reg granted_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      granted_q <= 1'b0;
      burst_request_in_n <= 1'b1;
      single_request_in_n <= 1'b1;
    end else if (clk_en) begin
      // grant seen: hold single request off until channel drops request
      if (!req_active) begin
        granted_q <= 1'b0;
      end else if (!burst_mode && xfer_start) begin
        granted_q <= 1'b1;
      end
      burst_request_in_n <= ~(req_active & burst_mode);
      single_request_in_n <= ~(req_active & ~burst_mode & ~xfer_start &
        ~granted_q);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // wait-state generator

  reg [`ADS_CNT_W-1:0] wait_eff;

  always @* begin
    wait_eff = (wait_cfg > WAIT_MAX) ? WAIT_MAX : wait_cfg;
    if (floor_en && wait_eff < WAIT_FLOOR) begin
      wait_eff = WAIT_FLOOR;
    end
    if (dma_en) begin
      wait_eff = WAIT_DMA;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= {`ADS_CNT_W{1'b0}};
      busy_q <= 1'b0;
      channel_ready <= 1'b1;
    end else if (clk_en) begin
      // chip enables that fall during a wait are ignored
      if (!busy_q) begin
        cnt_q <= wait_eff;
        if (ce_fall && wait_eff != {`ADS_CNT_W{1'b0}}) begin
          busy_q <= 1'b1;
          channel_ready <= 1'b0;
        end
      end else if (osc_rise) begin
        if (cnt_q == {{(`ADS_CNT_W-1){1'b0}}, 1'b1}) begin
          cnt_q <= wait_eff;
          busy_q <= 1'b0;
          channel_ready <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(`ADS_CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // general-purpose output port

  always @(posedge aclk) begin
    if (!aresetn) begin
      gp_out <= `ADS_PORT_RESET;
    end else if (clk_en) begin
      if (wr_fall && !sel_n_s) begin
        gp_out <= data_s;
      end
    end
  end

endmodule
`default_nettype wire

// ===== dv/ads_support_sva.sv
/*
 checker for the dma request selector, wait generator and output port.
 assumes the block's own port names; bound from the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module ads_support_sva (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic [1:0] serial_wait_request_n, // channel requests
  input wire logic bus_grant, // grant
  input wire logic status_s0_n, // status s0
  input wire logic status_s1_n, // status s1
  input wire logic serial_chip_enable_n, // serial select
  input wire logic decoded_select_n, // port select
  input wire logic io_write_strobe_n, // port strobe
  input wire logic [7:0] gp_out, // port lines
  input wire logic burst_request_in_n, // burst out
  input wire logic single_request_in_n, // single out
  input wire logic channel_ready, // ready
  input wire logic s_axi_bvalid, // write resp valid
  input wire logic s_axi_bready, // write resp ready
  input wire logic [1:0] s_axi_bresp // write resp
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  localparam int LOW_MAX = 128;
  logic [7:0] low_q;
  // cycles of the current wait
  always_ff @(posedge aclk) begin
    if (!aresetn || channel_ready) low_q <= 8'h00;
    else if (low_q != 8'hff) low_q <= low_q + 8'h01;
  end
////////////////////////////////////////////////////////////////////////
  property p_rst;
    $rose(aresetn) |-> channel_ready && burst_request_in_n &&
      single_request_in_n && gp_out == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_one;
    burst_request_in_n || single_request_in_n;
  endproperty
  a_one: assert property (p_one) else $error("both requests");
  property p_burst;
    $fell(burst_request_in_n) |-> !(&$past(serial_wait_request_n, 3));
  endproperty
  a_burst: assert property (p_burst) else $error("burst cause");
  property p_single;
    $fell(single_request_in_n) |-> !(&$past(serial_wait_request_n, 3));
  endproperty
  a_single: assert property (p_single) else $error("single cause");
  property p_gnt;
    (bus_grant && !status_s0_n && !status_s1_n) [*6] |->
      single_request_in_n;
  endproperty
  a_gnt: assert property (p_gnt) else $error("single kept");
  property p_ce;
    $fell(channel_ready) |-> !$past(serial_chip_enable_n, 3);
  endproperty
  a_ce: assert property (p_ce) else $error("wait cause");
  property p_len;
    low_q <= LOW_MAX;
  endproperty
  a_len: assert property (p_len) else $error("wait too long");
  property p_port;
    $changed(gp_out) |-> !$past(io_write_strobe_n, 2) &&
      !$past(decoded_select_n, 2);
  endproperty
  a_port: assert property (p_port) else $error("port cause");
  property p_bv;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bv: assert property (p_bv) else $error("bvalid dropped");
  c_burst: cover property ($fell(burst_request_in_n));
  c_single: cover property ($fell(single_request_in_n));
  c_wait: cover property ($fell(channel_ready));
endmodule
`default_nettype wire

// ===== dv/ads_host_model.sv
/*
 host side: free-running bus oscillator and the output port write cycle.
 assumes aclk from the bench; osc phase unrelated to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ads_host_model (
  input wire logic aclk, // clock
  output var logic osc, // bus oscillator
  output var logic decoded_select_n, // port select
  output var logic io_write_strobe_n, // port strobe
  output var logic [7:0] port_data // board data
);
  initial begin
    osc = 1'b0;
    decoded_select_n = 1'b1;
    io_write_strobe_n = 1'b1;
    port_data = 8'h00;
    #13;
    forever #40 osc = ~osc;
  end
  // data valid around the strobe, then shows the inverse
  task automatic put(input logic [7:0] d, input logic sel_n);
    @(posedge aclk);
    port_data <= d;
    decoded_select_n <= sel_n;
    repeat (4) @(posedge aclk);
    io_write_strobe_n <= 1'b0;
    repeat (8) @(posedge aclk);
    io_write_strobe_n <= 1'b1;
    repeat (4) @(posedge aclk);
    decoded_select_n <= 1'b1;
    port_data <= ~d;
    repeat (6) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ===== dv/test_ads_support.sv
/*
 bench: axi4-lite tasks, wait-length measurement, request and port tests.
 assumes ads_support, ads_host_model and ads_support_sva compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ads_defs.vh"
module test_ads_support;
  logic aclk = 0, aresetn = 0, clk_en = 1;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0] serial_wait_request_n = 2'b11;
  logic bus_grant = 0, status_s0_n = 1, status_s1_n = 1;
  logic serial_chip_enable_n = 1;
  wire logic osc, decoded_select_n, io_write_strobe_n, channel_ready;
  wire logic [7:0] port_data, gp_out;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, burst_request_in_n, single_request_in_n;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int err_count = 0, cmp_count = 0;
  logic [7:0] cv [7] = '{8'h84, 8'h00, 8'h30, 8'h60, 8'h70, 8'h91, 8'h13};
  int ne [7] = '{4, 0, 3, 6, 6, 6, 6};
  always #2 aclk = ~aclk;
  ads_support dut_u (.*);
  ads_host_model host_u (.*);
////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo();
    err_count++;
    $display("[FAIL] handshake expected answer seen none");
    complete_run();
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    int n;
    logic ta, tw;
    n = 0; ta = 0; tw = 0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && s_axi_awready === 1'b1) begin ta = 1; s_axi_awvalid <= 0; end
      if (!tw && s_axi_wready === 1'b1) begin tw = 1; s_axi_wvalid <= 0; end
      if (++n > 50) tmo();
    end
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge aclk);
      if (++n > 100) tmo();
    end
    s_axi_bready <= 0;
    chk("bresp", s_axi_bresp, r);
    @(posedge aclk);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin @(posedge aclk); if (++n > 50) tmo(); end
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do begin @(posedge aclk); if (++n > 100) tmo(); end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    chk("rdata", s_axi_rdata, d);
    chk("rresp", s_axi_rresp, r);
    @(posedge aclk);
  endtask
  // one serial access; low time must exceed e-1 oscillator periods of 20 cycles and not pass e periods plus 4 cycles
  task automatic meas(input int e);
    int c;
    c = 0;
    serial_chip_enable_n <= 0;
    repeat (200) begin @(posedge aclk); if (channel_ready === 1'b0) c++; end
    serial_chip_enable_n <= 1;
    repeat (4) @(posedge aclk);
    chk("wait", (e == 0) ? c == 0 : (c > (e - 1) * 20 && c <= e * 20 + 4), 1);
    chk("ready", channel_ready, 1'b1);
  endtask
  task automatic req(input logic [1:0] q, input logic g, input logic [1:0] o);
    serial_wait_request_n <= q;
    bus_grant <= g; status_s0_n <= !g; status_s1_n <= !g;
    repeat (8) @(posedge aclk);
    chk("requests", {burst_request_in_n, single_request_in_n}, o);
  endtask
////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk("pins", {channel_ready, burst_request_in_n, single_request_in_n,
        gp_out}, {3'b111, 8'h00});
    axr(`ADS_OFF_CONFIG, 32'h0000_0084, `ADS_RESP_OKAY);
    axr(4'hc, 32'h0000_0000, `ADS_RESP_DECERR);
    axw(`ADS_OFF_STATUS, 32'h0000_0000, `ADS_RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      axw(`ADS_OFF_CONFIG, {24'h0, cv[i]}, `ADS_RESP_OKAY);
      meas(ne[i]);
    end
    $display("test wait done");
    axw(`ADS_OFF_CONFIG, 32'h0000_0005, `ADS_RESP_OKAY);
    req(2'b10, 0, 2'b11);
    req(2'b01, 0, 2'b10);
    axr(`ADS_OFF_STATUS, 32'h0000_0615, `ADS_RESP_OKAY);
    req(2'b01, 1, 2'b11);
    req(2'b11, 0, 2'b11);
    axw(`ADS_OFF_CONFIG, 32'h0000_0003, `ADS_RESP_OKAY);
    req(2'b10, 1, 2'b01);
    meas(6);
    axw(`ADS_OFF_CONFIG, 32'h0000_0002, `ADS_RESP_OKAY);
    req(2'b10, 0, 2'b11);
    req(2'b11, 0, 2'b11);
    $display("test request done");
    host_u.put(8'ha5, 0);
    chk("gp_out", gp_out, 8'ha5);
    host_u.put(8'h3c, 1);
    chk("gp_out", gp_out, 8'ha5);
    clk_en <= 0;
    host_u.put(8'h5a, 0);
    chk("frozen", gp_out, 8'ha5);
    clk_en <= 1;
    axr(`ADS_OFF_PORT, 32'h0000_00a5, `ADS_RESP_OKAY);
    $display("test port done");
    complete_run();
  end
endmodule
bind ads_support ads_support_sva chk_u (.*);
`default_nettype wire
